// [hdl/dcx_debug_cmp_ext.sv]
// debug compare extension: three control registers and qualified compare events
// assumes special-register moves arrive as one-cycle strobes; comparator values,
// one/two, three/four and data pair modes and resource ownership come from the rest of the debug unit
//
// Overview of operation
// - polarity bit set inverts data value match
// - data comparator one mask ignores low bits
// - data comparator two mask ignores low bits
// - masking only in exact mode; reserved codes
// - power-on clears; processor reset respects ownership
// - privilege field qualifies comparators five to eight
// - address-space field qualifies comparators five to eight
// - five/six exact mode compares equality each
// - five/six bit mode masks by six
// - seven/eight exact mode compares equality each
// - seven/eight bit mode; reserved modes silent
// - instruction one/two masks in exact mode
// - instruction three/four masks in exact mode
// - instruction five/six masks in exact mode
// - instruction seven/eight masks in exact mode
// - shared debug writes touch software bits only
`timescale 1ns/1ps
module dcx_debug_cmp_ext #(
  parameter int ADDR_W = 32,
  parameter int DATA_W = 32
) (
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire logic                   proc_reset_n,
  input  wire logic                   external_debug_mode,
  input  wire logic [31:0]            sw_owned_data_ext,
  input  wire logic [31:0]            sw_owned_upper_instr,
  input  wire logic [31:0]            sw_owned_instr_mask,
  input  wire logic                   spr_wr_en,
  input  wire logic                   spr_rd_en,
  input  wire logic [9:0]             spr_num,
  input  wire logic [31:0]            spr_wdata,
  output logic      [31:0]            spr_rdata,
  output logic                        spr_rd_valid,
  output logic                        spr_rd_hit,
  input  wire logic                   fetch_valid,
  input  wire logic [ADDR_W-1:0]      fetch_addr,
  input  wire logic                   user_state_bit,
  input  wire logic                   instruction_space_bit,
  input  wire logic [7:0][ADDR_W-1:0] instr_cmp_value,
  input  wire logic [1:0]             instr_pair_one_two_mode,
  input  wire logic [1:0]             instr_pair_three_four_mode,
  input  wire logic                   data_valid,
  input  wire logic [ADDR_W-1:0]      data_addr,
  input  wire logic [1:0][ADDR_W-1:0] data_cmp_value,
  input  wire logic [1:0]             data_cmp_pair_mode,
  input  wire logic [DATA_W-1:0]      data_value,
  input  wire logic [DATA_W-1:0]      value_comparator_one,
  input  wire logic [DATA_W-1:0]      value_comparator_two,
  output logic      [7:0]             instr_event,
  output logic      [1:0]             data_addr_event,
  output logic      [1:0]             value_event
);

  logic [31:0] data_ext_reg;
  logic [31:0] data_ext_next;
  logic [31:0] upper_instr_reg;
  logic [31:0] upper_instr_next;
  logic [31:0] instr_mask_reg;
  logic [31:0] instr_mask_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic        rd_valid_reg;
  logic        rd_hit_reg;
  logic        rd_hit_next;
  logic [7:0]  instr_ev_reg;
  logic [7:0]  instr_ev_next;
  logic [1:0]  daddr_ev_reg;
  logic [1:0]  daddr_ev_next;
  logic [1:0]  val_ev_reg;
  logic [1:0]  val_ev_next;

  logic [7:0][1:0] instr_pm;
  logic [7:0]      instr_exact;
  logic [1:0]      data_exact;
  logic [3:0][1:0] up_priv;
  logic [3:0][1:0] up_space;
  logic [1:0]      pm56;
  logic [1:0]      pm78;
  logic            val_pol_one;
  logic            val_pol_two;

  assign pm56        = upper_instr_reg[dcx_pkg::POS_PAIR_56_MODE +: 2];
  assign pm78        = upper_instr_reg[dcx_pkg::POS_PAIR_78_MODE +: 2];
  assign val_pol_one = data_ext_reg[dcx_pkg::POS_VAL_ONE_POL];
  assign val_pol_two = data_ext_reg[dcx_pkg::POS_VAL_TWO_POL];

  // register file: processor reset beats a same-cycle software write
  always_comb begin
    data_ext_next    = data_ext_reg;
    upper_instr_next = upper_instr_reg;
    instr_mask_next  = instr_mask_reg;
    if (!proc_reset_n) begin
      if (!external_debug_mode) begin
        data_ext_next    = dcx_pkg::RESET_VAL;
        upper_instr_next = dcx_pkg::RESET_VAL;
        instr_mask_next  = dcx_pkg::RESET_VAL;
      end else begin
        data_ext_next    = data_ext_reg & ~sw_owned_data_ext;
        upper_instr_next = upper_instr_reg & ~sw_owned_upper_instr;
        instr_mask_next  = instr_mask_reg & ~sw_owned_instr_mask;
      end
    end else if (spr_wr_en) begin
      case (spr_num)
        dcx_pkg::SPR_DATA_EXT: begin
          data_ext_next = dcx_pkg::dcx_merge(data_ext_reg, spr_wdata,
                            dcx_pkg::WMASK_DATA_EXT, sw_owned_data_ext,
                            external_debug_mode);
        end
        dcx_pkg::SPR_UPPER_INSTR: begin
          upper_instr_next = dcx_pkg::dcx_merge(upper_instr_reg, spr_wdata,
                               dcx_pkg::WMASK_UPPER_INSTR, sw_owned_upper_instr,
                               external_debug_mode);
        end
        dcx_pkg::SPR_INSTR_MASK: begin
          instr_mask_next = dcx_pkg::dcx_merge(instr_mask_reg, spr_wdata,
                              dcx_pkg::WMASK_INSTR_MASK, sw_owned_instr_mask,
                              external_debug_mode);
        end
        default: begin
          data_ext_next = data_ext_reg;
        end
      endcase
    end
  end

  // read port: one cycle after the strobe; unknown numbers read zero
  always_comb begin
    rdata_next  = 32'h0000_0000;
    rd_hit_next = 1'b0;
    if (spr_rd_en) begin
      case (spr_num)
        dcx_pkg::SPR_DATA_EXT: begin
          rdata_next  = data_ext_reg & dcx_pkg::WMASK_DATA_EXT;
          rd_hit_next = 1'b1;
        end
        dcx_pkg::SPR_UPPER_INSTR: begin
          rdata_next  = upper_instr_reg & dcx_pkg::WMASK_UPPER_INSTR;
          rd_hit_next = 1'b1;
        end
        dcx_pkg::SPR_INSTR_MASK: begin
          rdata_next  = instr_mask_reg;
          rd_hit_next = 1'b1;
        end
        default: begin
          rdata_next  = 32'h0000_0000;
          rd_hit_next = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      data_ext_reg    <= dcx_pkg::RESET_VAL;
      upper_instr_reg <= dcx_pkg::RESET_VAL;
      instr_mask_reg  <= dcx_pkg::RESET_VAL;
      rdata_reg       <= 32'h0000_0000;
      rd_valid_reg    <= 1'b0;
      rd_hit_reg      <= 1'b0;
    end else begin
      data_ext_reg    <= data_ext_next;
      upper_instr_reg <= upper_instr_next;
      instr_mask_reg  <= instr_mask_next;
      rdata_reg       <= rdata_next;
      rd_valid_reg    <= spr_rd_en;
      rd_hit_reg      <= rd_hit_next;
    end
  end

  // pair mode and qualifier fields per comparator
  always_comb begin
    instr_pm[0] = instr_pair_one_two_mode;
    instr_pm[1] = instr_pair_one_two_mode;
    instr_pm[2] = instr_pair_three_four_mode;
    instr_pm[3] = instr_pair_three_four_mode;
    instr_pm[4] = pm56;
    instr_pm[5] = pm56;
    instr_pm[6] = pm78;
    instr_pm[7] = pm78;
    up_priv[0]  = upper_instr_reg[dcx_pkg::POS_QUAL_FIVE + 2 +: 2];
    up_space[0] = upper_instr_reg[dcx_pkg::POS_QUAL_FIVE +: 2];
    up_priv[1]  = upper_instr_reg[dcx_pkg::POS_QUAL_SIX + 2 +: 2];
    up_space[1] = upper_instr_reg[dcx_pkg::POS_QUAL_SIX +: 2];
    up_priv[2]  = upper_instr_reg[dcx_pkg::POS_QUAL_SEVEN + 2 +: 2];
    up_space[2] = upper_instr_reg[dcx_pkg::POS_QUAL_SEVEN +: 2];
    up_priv[3]  = upper_instr_reg[dcx_pkg::POS_QUAL_EIGHT + 2 +: 2];
    up_space[3] = upper_instr_reg[dcx_pkg::POS_QUAL_EIGHT +: 2];
  end

  for (genvar gi = 0; gi < 8; gi++) begin : g_instr_cmp
    dcx_addr_cmp #(
      .ADDR_W (ADDR_W)
    ) u_cmp (
      .addr      (fetch_addr),
      .cmp_value (instr_cmp_value[gi]),
      .mask_code (instr_mask_reg[dcx_pkg::POS_INSTR_XM_TOP - dcx_pkg::XM_W*gi -: 4]),
      .pair_mode (instr_pm[gi]),
      .exact_hit (instr_exact[gi])
    );
  end

  dcx_addr_cmp #(
    .ADDR_W (ADDR_W)
  ) u_data_one (
    .addr      (data_addr),
    .cmp_value (data_cmp_value[0]),
    .mask_code (data_ext_reg[dcx_pkg::POS_DATA_ONE_XM +: 4]),
    .pair_mode (data_cmp_pair_mode),
    .exact_hit (data_exact[0])
  );

  dcx_addr_cmp #(
    .ADDR_W (ADDR_W)
  ) u_data_two (
    .addr      (data_addr),
    .cmp_value (data_cmp_value[1]),
    .mask_code (data_ext_reg[dcx_pkg::POS_DATA_TWO_XM +: 4]),
    .pair_mode (data_cmp_pair_mode),
    .exact_hit (data_exact[1])
  );

  // event computation, registered before leaving the block
  always_comb begin
    instr_ev_next = 8'h00;
    for (int k = 0; k < 4; k++) begin
      instr_ev_next[k] = fetch_valid & instr_exact[k];
    end
    for (int k = 0; k < 4; k++) begin
      if (instr_pm[4+k] == dcx_pkg::PAIR_EXACT) begin
        instr_ev_next[4+k] = fetch_valid & instr_exact[4+k] &
          dcx_pkg::dcx_qual_ok(up_priv[k], up_space[k], user_state_bit,
                               instruction_space_bit);
      end
    end
    if (pm56 == dcx_pkg::PAIR_BITMATCH) begin
      instr_ev_next[4] = fetch_valid &
        ((fetch_addr & instr_cmp_value[5]) == (instr_cmp_value[4] & instr_cmp_value[5])) &
        dcx_pkg::dcx_qual_ok(up_priv[0], up_space[0], user_state_bit,
                             instruction_space_bit);
    end
    if (pm78 == dcx_pkg::PAIR_BITMATCH) begin
      instr_ev_next[6] = fetch_valid &
        ((fetch_addr & instr_cmp_value[7]) == (instr_cmp_value[6] & instr_cmp_value[7])) &
        dcx_pkg::dcx_qual_ok(up_priv[2], up_space[2], user_state_bit,
                             instruction_space_bit);
    end
    daddr_ev_next = {data_valid & data_exact[1], data_valid & data_exact[0]};
    val_ev_next[0] = data_valid & ((data_value == value_comparator_one) ^ val_pol_one);
    val_ev_next[1] = data_valid & ((data_value == value_comparator_two) ^ val_pol_two);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      instr_ev_reg <= 8'h00;
      daddr_ev_reg <= 2'h0;
      val_ev_reg   <= 2'h0;
    end else begin
      instr_ev_reg <= instr_ev_next;
      daddr_ev_reg <= daddr_ev_next;
      val_ev_reg   <= val_ev_next;
    end
  end

  assign spr_rdata       = rdata_reg;
  assign spr_rd_valid    = rd_valid_reg;
  assign spr_rd_hit      = rd_hit_reg;
  assign instr_event     = instr_ev_reg;
  assign data_addr_event = daddr_ev_reg;
  assign value_event     = val_ev_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_value_inverted: assert property (data_valid && val_pol_one &&
    data_value == value_comparator_one |=> !value_event[0])
    else $error("inverted polarity still matched on equality");

  a_value_normal: assert property (data_valid && !val_pol_two &&
    data_value != value_comparator_two |=> !value_event[1])
    else $error("normal polarity matched on inequality");

  a_data_mask_hit: assert property (data_valid && data_cmp_pair_mode == 2'b00 &&
    data_ext_reg[15:12] == 4'hc && (data_addr[ADDR_W-1:12] == data_cmp_value[0][ADDR_W-1:12])
    |=> data_addr_event[0])
    else $error("masked data compare one missed");

  a_data_mode_gate: assert property (data_cmp_pair_mode != 2'b00 |=>
    data_addr_event == 2'h0)
    else $error("data compare fired outside exact mode");

  a_reserved_zero: assert property (
    (data_ext_reg & ~dcx_pkg::WMASK_DATA_EXT) == 32'h0 &&
    (upper_instr_reg & ~dcx_pkg::WMASK_UPPER_INSTR) == 32'h0)
    else $error("reserved bit became set");

  a_proc_reset_clr: assert property (!proc_reset_n && !external_debug_mode |=>
    data_ext_reg == 32'h0 && upper_instr_reg == 32'h0 && instr_mask_reg == 32'h0)
    else $error("processor reset left a register set");

  a_shared_write: assert property (external_debug_mode && proc_reset_n && spr_wr_en |=>
    ((upper_instr_reg ^ $past(upper_instr_reg)) & ~$past(sw_owned_upper_instr)) == 32'h0)
    else $error("write changed a debugger owned bit");

  a_priv_super: assert property (fetch_valid && user_state_bit &&
    upper_instr_reg[31:30] == 2'b10 |=> !instr_event[4])
    else $error("supervisor only comparator fired in user state");

  a_space_none: assert property (upper_instr_reg[13:12] == 2'b01 |=> !instr_event[6])
    else $error("space code 01 produced an event");

  a_six_quiet: assert property (pm56 == 2'b01 |=> !instr_event[5])
    else $error("comparator six fired in bit match mode");

  a_rsvd_pair78: assert property (pm78[1] |=> instr_event[7:6] == 2'b00)
    else $error("reserved pair mode produced events");

  a_instr_mask_hit: assert property (fetch_valid && instr_pair_one_two_mode == 2'b00 &&
    instr_mask_reg[31:28] == 4'h4 && fetch_addr[ADDR_W-1:4] == instr_cmp_value[0][ADDR_W-1:4]
    |=> instr_event[0])
    else $error("masked instruction compare one missed");

  a_read_return: assert property (spr_rd_valid == $past(spr_rd_en))
    else $error("read answer not one cycle after strobe");

  c_bitmatch_five: cover property (pm56 == 2'b01 ##1 instr_event[4]);
  c_inverted_hit: cover property (val_pol_one ##1 value_event[0]);
  c_shared_reset: cover property (!proc_reset_n && external_debug_mode);
  c_data_masked: cover property (data_ext_reg[15:12] != 4'h0 ##1 data_addr_event[0]);

endmodule : dcx_debug_cmp_ext

// [hdl/dcx_pkg.sv]
// constants, mode types and helper functions for the debug compare extension block
// assumes 32-bit registers with bit 0 as the most significant bit in field naming
package dcx_pkg;

  // special-register numbers
  localparam logic [9:0]  SPR_DATA_EXT    = 10'h233;
  localparam logic [9:0]  SPR_UPPER_INSTR = 10'h234;
  localparam logic [9:0]  SPR_INSTR_MASK  = 10'h25b;

  localparam logic [31:0] RESET_VAL       = 32'h0000_0000;

  // implemented bits of each register, everything else is reserved
  localparam logic [31:0] WMASK_DATA_EXT    = 32'h5000_ff00;
  localparam logic [31:0] WMASK_UPPER_INSTR = 32'hffc0_ffc0;
  localparam logic [31:0] WMASK_INSTR_MASK  = 32'hffff_ffff;

  // data_compare_extension_ctrl field positions (lsb index)
  localparam int POS_VAL_ONE_POL  = 30;
  localparam int POS_VAL_TWO_POL  = 28;
  localparam int POS_DATA_ONE_XM  = 12;
  localparam int POS_DATA_TWO_XM  = 8;

  // upper_instr_compare_ctrl field positions (lsb index)
  localparam int POS_PAIR_56_MODE = 22;
  localparam int POS_PAIR_78_MODE = 6;
  localparam int POS_QUAL_FIVE    = 28;
  localparam int POS_QUAL_SIX     = 24;
  localparam int POS_QUAL_SEVEN   = 12;
  localparam int POS_QUAL_EIGHT   = 8;

  // instr_compare_mask_ctrl: comparator n mask at [31-4n -: 4]
  localparam int POS_INSTR_XM_TOP = 31;
  localparam int XM_W             = 4;

  localparam logic [3:0]  MASK_CODE_MIN = 4'h1;
  localparam logic [3:0]  MASK_CODE_MAX = 4'hc;

  typedef enum logic [1:0] {
    PAIR_EXACT    = 2'b00,
    PAIR_BITMATCH = 2'b01,
    PAIR_RSVD_A   = 2'b10,
    PAIR_RSVD_B   = 2'b11
  } dcx_pair_e;

  typedef enum logic [1:0] {
    PRIV_ANY   = 2'b00,
    PRIV_RSVD  = 2'b01,
    PRIV_SUPER = 2'b10,
    PRIV_USER  = 2'b11
  } dcx_priv_e;

  typedef enum logic [1:0] {
    SPACE_EFF  = 2'b00,
    SPACE_NONE = 2'b01,
    SPACE_IS0  = 2'b10,
    SPACE_IS1  = 2'b11
  } dcx_space_e;

  // low-order address bits ignored for a mask code; reserved codes mask nothing
  function automatic logic [31:0] dcx_ext_mask(input logic [3:0] code);
    dcx_ext_mask = 32'h0000_0000;
    if (code >= MASK_CODE_MIN && code <= MASK_CODE_MAX) begin
      dcx_ext_mask = (32'h0000_0001 << code) - 32'h0000_0001;
    end
  endfunction : dcx_ext_mask

  // software write: under shared debug only software-owned bits change
  function automatic logic [31:0] dcx_merge(input logic [31:0] old_val,
                                            input logic [31:0] wdata,
                                            input logic [31:0] wmask,
                                            input logic [31:0] sw_owned,
                                            input logic        ext_dbg);
    logic [31:0] m;
    m = ext_dbg ? (wmask & sw_owned) : wmask;
    dcx_merge = (old_val & ~m) | (wdata & m);
  endfunction : dcx_merge

  // privilege and address-space qualifiers; reserved privilege never matches
  function automatic logic dcx_qual_ok(input logic [1:0] priv,
                                       input logic [1:0] space,
                                       input logic       user_st,
                                       input logic       is_bit);
    logic p_ok;
    logic s_ok;
    case (priv)
      PRIV_ANY:   p_ok = 1'b1;
      PRIV_SUPER: p_ok = !user_st;
      PRIV_USER:  p_ok = user_st;
      default:    p_ok = 1'b0;
    endcase
    case (space)
      SPACE_EFF: s_ok = 1'b1;
      SPACE_IS0: s_ok = !is_bit;
      SPACE_IS1: s_ok = is_bit;
      default:   s_ok = 1'b0;
    endcase
    dcx_qual_ok = p_ok & s_ok;
  endfunction : dcx_qual_ok

endpackage : dcx_pkg

// [hdl/dcx_addr_cmp.sv]
// one address comparator with power-of-two extended mask in exact mode
// assumes the caller registers the result; purely combinational
`timescale 1ns/1ps
module dcx_addr_cmp #(
  parameter int ADDR_W = 32
) (
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [ADDR_W-1:0] cmp_value,
  input  wire logic [3:0]        mask_code,
  input  wire logic [1:0]        pair_mode,
  output logic                   exact_hit
);

  logic [31:0]       ign_full;
  logic [ADDR_W-1:0] ign;

  always_comb begin
    ign_full  = dcx_pkg::dcx_ext_mask(mask_code);
    ign       = ign_full[ADDR_W-1:0];
    // masking and the match itself count only in exact pair mode
    exact_hit = (pair_mode == dcx_pkg::PAIR_EXACT) &&
                (((addr ^ cmp_value) & ~ign) == '0);
  end

endmodule : dcx_addr_cmp

// [verification/dcx_debug_cmp_ext_tb.sv]
// self-checking testbench for the debug compare extension block
// assumes the block answers reads one cycle after the request and events one cycle after inputs
`timescale 1ns/1ps
module dcx_debug_cmp_ext_tb;
  localparam int LIMIT = 20000;
  localparam int ITERS = 300;

  logic                   clk;
  logic                   rst_n;
  logic                   proc_reset_n;
  logic                   external_debug_mode;
  logic                   spr_wr_en;
  logic                   spr_rd_en;
  logic [9:0]             spr_num;
  logic [31:0]            spr_wdata;
  logic [31:0]            spr_rdata;
  logic                   spr_rd_valid;
  logic                   spr_rd_hit;
  logic                   fetch_valid;
  logic [31:0]            fetch_addr;
  logic                   user_state_bit;
  logic                   instruction_space_bit;
  logic [7:0][31:0]       icv;
  logic [1:0]             m12;
  logic [1:0]             m34;
  logic                   data_valid;
  logic [31:0]            data_addr;
  logic [1:0][31:0]       dcv;
  logic [1:0]             dpm;
  logic [31:0]            data_value;
  logic [31:0]            vc1;
  logic [31:0]            vc2;
  logic [7:0]             instr_event;
  logic [1:0]             data_addr_event;
  logic [1:0]             value_event;
  logic [31:0]            sh [0:3];
  logic [31:0]            own [0:3];
  logic [31:0]            wm [0:3];
  logic [9:0]             nums [0:3];
  logic [31:0]            base;
  logic [7:0]             ei;
  int                     err_total;
  int                     n_checks;
  int                     cycles;

  dcx_debug_cmp_ext DUT (
    .clk(clk), .rst_n(rst_n), .proc_reset_n(proc_reset_n),
    .external_debug_mode(external_debug_mode), .sw_owned_data_ext(own[0]),
    .sw_owned_upper_instr(own[1]), .sw_owned_instr_mask(own[2]),
    .spr_wr_en(spr_wr_en), .spr_rd_en(spr_rd_en), .spr_num(spr_num), .spr_wdata(spr_wdata),
    .spr_rdata(spr_rdata), .spr_rd_valid(spr_rd_valid), .spr_rd_hit(spr_rd_hit),
    .fetch_valid(fetch_valid), .fetch_addr(fetch_addr), .user_state_bit(user_state_bit),
    .instruction_space_bit(instruction_space_bit), .instr_cmp_value(icv),
    .instr_pair_one_two_mode(m12), .instr_pair_three_four_mode(m34),
    .data_valid(data_valid), .data_addr(data_addr), .data_cmp_value(dcv),
    .data_cmp_pair_mode(dpm), .data_value(data_value), .value_comparator_one(vc1),
    .value_comparator_two(vc2), .instr_event(instr_event),
    .data_addr_event(data_addr_event), .value_event(value_event)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      err_total++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // ignored low bits; codes outside 1..12 mask nothing
  function automatic logic [31:0] xm(input logic [3:0] c);
    return (c >= 4'h1 && c <= 4'hc) ? ((32'h1 << c) - 32'h1) : 32'h0;
  endfunction : xm

  function automatic logic qual(input logic [3:0] n);
    logic p;
    logic s;
    p = (n[3:2] == 2'h0) || (n[3:2] == 2'h2 && !user_state_bit)
        || (n[3:2] == 2'h3 && user_state_bit);
    s = (n[1:0] == 2'h0) || (n[1:0] == 2'h2 && !instruction_space_bit)
        || (n[1:0] == 2'h3 && instruction_space_bit);
    return p && s;
  endfunction : qual

  function automatic logic [7:0] exp_instr();
    logic [7:0] e;
    logic [1:0] pm;
    logic       q;
    int         qp;
    for (int k = 0; k < 8; k++) begin
      pm = (k < 2) ? m12 : (k < 4) ? m34 : (k < 6) ? sh[1][23:22] : sh[1][7:6];
      qp = (k == 4) ? 28 : (k == 5) ? 24 : (k == 6) ? 12 : 8;
      q = (k < 4) ? 1'b1 : qual(sh[1][qp +: 4]);
      e[k] = (pm == 2'h0) && (((fetch_addr ^ icv[k]) & ~xm(sh[2][31-4*k -: 4])) == 32'h0) && q;
      if ((k == 4 || k == 6) && pm == 2'h1) begin
        e[k] = ((fetch_addr & icv[k+1]) == (icv[k] & icv[k+1])) && q;
      end
    end
    return fetch_valid ? e : 8'h00;
  endfunction : exp_instr

  function automatic logic [3:0] exp_data();
    logic [3:0] e;
    for (int j = 0; j < 2; j++) begin
      e[j] = (dpm == 2'h0) && (((data_addr ^ dcv[j]) & ~xm(sh[0][15-4*j -: 4])) == 32'h0);
    end
    e[2] = (data_value == vc1) ^ sh[0][30];
    e[3] = (data_value == vc2) ^ sh[0][28];
    return data_valid ? e : 4'h0;
  endfunction : exp_data

  // holds the write strobe up; the caller lowers it
  task automatic wr(input int i, input logic [31:0] d);
    logic [31:0] m;
    m = external_debug_mode ? (wm[i] & own[i]) : wm[i];
    spr_wr_en = 1'b1;
    spr_num = nums[i];
    spr_wdata = d;
    @(negedge clk);
    sh[i] = (sh[i] & ~m) | (d & m);
  endtask : wr

  task automatic rd(input int i);
    spr_rd_en = 1'b1;
    spr_num = nums[i];
    @(negedge clk);
    chk(32'(spr_rd_valid), 32'h1);
    chk(32'(spr_rd_hit), 32'(i < 3));
    chk(spr_rdata, sh[i]);
  endtask : rd

  initial begin
    nums = '{dcx_pkg::SPR_DATA_EXT, dcx_pkg::SPR_UPPER_INSTR, dcx_pkg::SPR_INSTR_MASK, 10'h235};
    wm = '{dcx_pkg::WMASK_DATA_EXT, dcx_pkg::WMASK_UPPER_INSTR, dcx_pkg::WMASK_INSTR_MASK, 32'h0};
    sh = '{default: 32'h0};
    own = '{default: 32'h0};
    {rst_n, proc_reset_n, external_debug_mode, spr_wr_en, spr_rd_en} = 5'b01000;
    {spr_num, spr_wdata, fetch_valid, fetch_addr, user_state_bit} = '0;
    {instruction_space_bit, icv, m12, m34, data_valid, data_addr} = '0;
    {dcv, dpm, data_value, vc1, vc2} = '0;
    void'($urandom(32'he588b128));
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    for (int i = 0; i < 4; i++) rd(i);
    spr_rd_en = 1'b0;
    for (int it = 0; it < ITERS; it++) begin
      external_debug_mode = ($urandom_range(0, 3) == 0);
      for (int i = 0; i < 3; i++) own[i] = $urandom;
      for (int i = 0; i < 4; i++) wr(i, (it < 2) ? 32'hffff_ffff : $urandom);
      spr_wr_en = 1'b0;
      if ($urandom_range(0, 7) == 0) begin
        proc_reset_n = 1'b0;
        @(negedge clk);
        proc_reset_n = 1'b1;
        for (int i = 0; i < 3; i++) sh[i] = external_debug_mode ? (sh[i] & ~own[i]) : 32'h0;
      end
      for (int i = 0; i < 4; i++) rd(i);
      spr_rd_en = 1'b0;
      base = $urandom;
      for (int k = 0; k < 8; k++) icv[k] = base ^ ($urandom & 32'h1fff);
      if ($urandom_range(0, 1)) icv[5] = $urandom & 32'hffff_e000;
      if ($urandom_range(0, 1)) icv[7] = $urandom & 32'hffff_e000;
      fetch_addr = $urandom_range(0, 1) ? icv[$urandom_range(0, 7)] : base ^ ($urandom & 32'h1fff);
      m12 = $urandom_range(0, 1) ? 2'h0 : 2'($urandom);
      m34 = $urandom_range(0, 1) ? 2'h0 : 2'($urandom);
      dpm = $urandom_range(0, 1) ? 2'h0 : 2'($urandom);
      {fetch_valid, data_valid, user_state_bit, instruction_space_bit} = 4'($urandom);
      dcv[0] = base ^ ($urandom & 32'h1fff);
      dcv[1] = base ^ ($urandom & 32'h1fff);
      data_addr = $urandom_range(0, 1) ? dcv[$urandom_range(0, 1)] : base ^ ($urandom & 32'h1fff);
      data_value = $urandom;
      vc1 = $urandom_range(0, 1) ? data_value : $urandom;
      vc2 = $urandom_range(0, 1) ? data_value : $urandom;
      @(negedge clk);
      chk(32'(spr_rd_valid), 32'h0);
      ei = exp_instr();
      chk(32'(instr_event[3:0]), 32'(ei[3:0]));
      chk(32'(instr_event[5:4]), 32'(ei[5:4]));
      chk(32'(instr_event[7:6]), 32'(ei[7:6]));
      chk(32'(data_addr_event), 32'(exp_data() & 4'h3));
      chk(32'(value_event), 32'(exp_data() >> 2));
    end
    external_debug_mode = 1'b0;
    rst_n = 1'b0;
    @(negedge clk);
    chk(32'(instr_event), 32'h0);
    chk(32'({data_addr_event, value_event, spr_rd_valid}), 32'h0);
    rst_n = 1'b1;
    sh = '{default: 32'h0};
    for (int i = 0; i < 4; i++) rd(i);
    spr_rd_en = 1'b0;
    report_and_stop();
  end
endmodule : dcx_debug_cmp_ext_tb
